// ### include/sscol_pkg.sv
package sscol_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int BAUD_W = 8;                 // Width of the baud reload value and counter
  localparam int PIN_W = 2;                  // Number of sampled bus lines
  localparam int PIN_SDA = 0;                // Index of SDA in the pin vector
  localparam int PIN_SCL = 1;                // Index of SCL in the pin vector

  typedef logic [BAUD_W-1:0] baud_t;         // Baud counter word
  typedef logic [PIN_W-1:0] pins_t;          // Sampled pin vector

  // ---------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------
  localparam baud_t BAUD_ZERO = 8'h00;       // Counter expiry value
  localparam baud_t BAUD_ONE = 8'h01;        // Counter decrement step
  localparam logic CMD_START = 1'b0;         // Command code for a Start
  localparam logic CMD_STOP = 1'b1;          // Command code for a Stop
  localparam logic LINE_FREE = 1'b0;         // Output enable value of a released line
  localparam logic LINE_PULL = 1'b1;         // Output enable value of a line pulled low
  localparam logic DRIVE_LEVEL = 1'b0;       // Level driven while the enable is high
  localparam pins_t PINS_IDLE = 2'h3;        // Reset value of the sampled pins (both high)
  localparam logic TGL_INIT = 1'b0;          // Reset value of every toggle

  // ---------------------------------------------------------------
  // Link state machine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,                          // Waiting for a command
    ST_START_BRG1 = 3'h1,                    // First Start count, SDA released
    ST_START_BRG2 = 3'h2,                    // Second Start count, SDA driven low
    ST_STOP_SDA = 3'h3,                      // Stop: waiting for SDA to read low
    ST_STOP_SCL = 3'h4,                      // Stop: SCL released, waiting for it high
    ST_STOP_BRG = 3'h5,                      // Stop: counting with SCL high
    ST_STOP_CHK = 3'h6                       // Stop: SDA released, counting before the check
  } link_state_e;

endpackage

// ### rtl/sscol_sync.sv
`timescale 1ns/1ps
// Three flop synchroniser; output follows once stages two and three agree
module sscol_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;                        // First stage, read by the second only
    logic [W-1:0] s2;                        // Second stage
    logic [W-1:0] s3;                        // Third stage
    logic [W-1:0] q;                         // Filtered output
  } sync_s;

  sync_s r;
  sync_s next_r;

  // Shift chain and agreement filter
  always_comb begin
    next_r = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      // Accept a bit only when two settled stages agree
      if (r.s2[i] == r.s3[i]) begin
        next_r.q[i] = r.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= {INIT, INIT, INIT, INIT};
    end else begin
      r <= next_r;
    end
  end

  assign q = r.q;

endmodule

// ### rtl/sscol_top.sv
`timescale 1ns/1ps
// Contract
// - Start with SDA or SCL low collides
// - SCL low while SDA high collides
// - Start collision aborts, flags, returns idle
// - Start releases lines, loads baud counter
// - Early SDA low resets counter, drives SDA
// - First count expiry drives SDA low
// - Reload counter, ignore SCL low meanwhile
// - Second count expiry drives SCL low
// - Foreign Start is not a collision
// - Stop drives SDA low, then releases SCL
// - SCL high loads counter from reload
// - SDA low after count collides
// - SCL low before SDA release collides
module sscol_top (
  // System clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Link clock
  input wire logic LINK_CLK,
  // User requests
  input wire logic START_REQ,
  input wire logic STOP_REQ,
  input wire logic [sscol_pkg::BAUD_W-1:0] BAUD_RELOAD,
  input wire logic COLLISION_CLEAR,
  // User status
  output logic BUSY,
  output logic DONE,
  output logic BUS_COLLISION_FLAG,
  // SDA line
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // SCL line
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE
);

  // ---------------------------------------------------------------
  // System side state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic busy;                              // A command is in flight
    logic cmd;                               // Command code held for the link
    sscol_pkg::baud_t reload;                // Baud reload value held for the link
    logic req_tgl;                           // Flips once per issued command
    logic ack_seen;                          // Last acknowledge toggle taken
    logic done;                              // One cycle completion pulse
    logic coll_flag;                         // Sticky collision flag
  } sys_s;

  // ---------------------------------------------------------------
  // Link side state
  // ---------------------------------------------------------------
  typedef struct packed {
    sscol_pkg::link_state_e state;           // Sequence state
    sscol_pkg::baud_t cnt;                   // Baud counter
    logic sda_oe;                            // SDA pulled low when set
    logic scl_oe;                            // SCL pulled low when set
    logic sda_out;                           // Level driven on SDA
    logic scl_out;                           // Level driven on SCL
    logic req_seen;                          // Last request toggle taken
    logic ack_tgl;                           // Flips once per finished command
    logic coll;                              // Result of the last command
  } link_s;

  sys_s s;
  sys_s next_s;
  link_s l;
  link_s next_l;

  // Synchronised signals
  sscol_pkg::pins_t pins;                    // Filtered SDA and SCL in the link domain
  logic req_tgl_l;                           // Request toggle in the link domain
  logic ack_tgl_s;                           // Acknowledge toggle in the system domain

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------

  // True once the baud counter has reached zero
  function automatic logic baud_expired(input sscol_pkg::baud_t c);
    baud_expired = (c == sscol_pkg::BAUD_ZERO);
  endfunction

  // Counter value one step lower, held at zero
  function automatic sscol_pkg::baud_t baud_step(input sscol_pkg::baud_t c);
    if (c == sscol_pkg::BAUD_ZERO) begin
      baud_step = sscol_pkg::BAUD_ZERO;
    end else begin
      baud_step = c - sscol_pkg::BAUD_ONE;
    end
  endfunction

  // ---------------------------------------------------------------
  // Crossings
  // ---------------------------------------------------------------

  // Bus lines into the link domain
  sscol_sync #(
    .W(sscol_pkg::PIN_W),
    .INIT(sscol_pkg::PINS_IDLE)
  ) u_pin_sync (
    .clk(LINK_CLK),
    .rst(RST),
    .d({SCL_IN, SDA_IN}),
    .q(pins)
  );

  // Command toggle into the link domain
  sscol_sync #(
    .W(1),
    .INIT(sscol_pkg::TGL_INIT)
  ) u_req_sync (
    .clk(LINK_CLK),
    .rst(RST),
    .d(s.req_tgl),
    .q(req_tgl_l)
  );

  // Completion toggle into the system domain
  sscol_sync #(
    .W(1),
    .INIT(sscol_pkg::TGL_INIT)
  ) u_ack_sync (
    .clk(MCLK),
    .rst(RST),
    .d(l.ack_tgl),
    .q(ack_tgl_s)
  );

  // ---------------------------------------------------------------
  // System side logic
  // ---------------------------------------------------------------

  // Accept one command at a time, collect the result
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    // New command only while idle; Start wins if both arrive together
    if (!s.busy && (START_REQ || STOP_REQ)) begin
      next_s.cmd = START_REQ ? sscol_pkg::CMD_START : sscol_pkg::CMD_STOP;
      next_s.reload = BAUD_RELOAD;
      next_s.req_tgl = ~s.req_tgl;
      next_s.busy = 1'b1;
    end
    // Software clear of the sticky flag
    if (COLLISION_CLEAR) begin
      next_s.coll_flag = 1'b0;
    end
    // Completion: result word is stable before its toggle arrives
    if (ack_tgl_s != s.ack_seen) begin
      next_s.ack_seen = ack_tgl_s;
      next_s.busy = 1'b0;
      next_s.done = 1'b1;
      // Set placed after the clear so a collision is never lost
      if (l.coll) begin
        next_s.coll_flag = 1'b1;
      end
    end
  end

  // System state register
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      s <= '{
        busy: 1'b0,
        cmd: sscol_pkg::CMD_START,
        reload: sscol_pkg::BAUD_ZERO,
        req_tgl: sscol_pkg::TGL_INIT,
        ack_seen: sscol_pkg::TGL_INIT,
        done: 1'b0,
        coll_flag: 1'b0
      };
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Link side logic
  // ---------------------------------------------------------------

  // Start and Stop sequencer with collision checks
  always_comb begin
    logic sda;
    logic scl;
    logic collide;
    logic finish;
    sda = pins[sscol_pkg::PIN_SDA];
    scl = pins[sscol_pkg::PIN_SCL];
    collide = 1'b0;
    finish = 1'b0;
    next_l = l;
    next_l.sda_out = sscol_pkg::DRIVE_LEVEL;
    next_l.scl_out = sscol_pkg::DRIVE_LEVEL;
    unique case (l.state)
      // Wait for a new command toggle
      sscol_pkg::ST_IDLE: begin
        if (req_tgl_l != l.req_seen) begin
          next_l.req_seen = req_tgl_l;
          if (s.cmd == sscol_pkg::CMD_START) begin
            // Lines already low from someone else: abort at once
            if (!sda || !scl) begin
              collide = 1'b1;
            end else begin
              // Both lines free and SDA high: load and count
              next_l.sda_oe = sscol_pkg::LINE_FREE;
              next_l.scl_oe = sscol_pkg::LINE_FREE;
              next_l.cnt = s.reload;
              next_l.state = sscol_pkg::ST_START_BRG1;
            end
          end else begin
            // Stop opens with SDA pulled low and SCL held low
            next_l.sda_oe = sscol_pkg::LINE_PULL;
            next_l.scl_oe = sscol_pkg::LINE_PULL;
            next_l.state = sscol_pkg::ST_STOP_SDA;
          end
        end
      end
      // First Start count with SDA released
      sscol_pkg::ST_START_BRG1: begin
        if (!scl && sda) begin
          // Another master drives a data one
          collide = 1'b1;
        end else if (!sda) begin
          // Another master started first; not a collision, assert early
          next_l.sda_oe = sscol_pkg::LINE_PULL;
          next_l.cnt = s.reload;
          next_l.state = sscol_pkg::ST_START_BRG2;
        end else if (baud_expired(l.cnt)) begin
          // SDA stayed high through the count
          next_l.sda_oe = sscol_pkg::LINE_PULL;
          next_l.cnt = s.reload;
          next_l.state = sscol_pkg::ST_START_BRG2;
        end else begin
          next_l.cnt = baud_step(l.cnt);
        end
      end
      // Second Start count; SCL is not checked here
      sscol_pkg::ST_START_BRG2: begin
        if (baud_expired(l.cnt)) begin
          next_l.scl_oe = sscol_pkg::LINE_PULL;
          finish = 1'b1;
        end else begin
          next_l.cnt = baud_step(l.cnt);
        end
      end
      // Stop: once SDA reads low, let SCL float
      sscol_pkg::ST_STOP_SDA: begin
        if (!sda) begin
          next_l.scl_oe = sscol_pkg::LINE_FREE;
          next_l.state = sscol_pkg::ST_STOP_SCL;
        end
      end
      // Stop: clock arbitration, wait for SCL high
      sscol_pkg::ST_STOP_SCL: begin
        if (scl) begin
          next_l.cnt = s.reload;
          next_l.state = sscol_pkg::ST_STOP_BRG;
        end
      end
      // Stop: count with SCL high, SDA still held low
      sscol_pkg::ST_STOP_BRG: begin
        if (!scl) begin
          // SCL pulled low before SDA was let go
          collide = 1'b1;
        end else if (baud_expired(l.cnt)) begin
          next_l.sda_oe = sscol_pkg::LINE_FREE;
          next_l.cnt = s.reload;
          next_l.state = sscol_pkg::ST_STOP_CHK;
        end else begin
          next_l.cnt = baud_step(l.cnt);
        end
      end
      // Stop: SDA released; sample it after the count
      sscol_pkg::ST_STOP_CHK: begin
        if (baud_expired(l.cnt)) begin
          if (!sda) begin
            collide = 1'b1;
          end else begin
            finish = 1'b1;
          end
        end else begin
          next_l.cnt = baud_step(l.cnt);
        end
      end
      default: begin
        // Illegal code: release and fall back to idle
        next_l.sda_oe = sscol_pkg::LINE_FREE;
        next_l.scl_oe = sscol_pkg::LINE_FREE;
        next_l.state = sscol_pkg::ST_IDLE;
      end
    endcase
    // Abort: release both lines, report and go idle
    if (collide) begin
      next_l.sda_oe = sscol_pkg::LINE_FREE;
      next_l.scl_oe = sscol_pkg::LINE_FREE;
      next_l.coll = 1'b1;
      next_l.ack_tgl = ~l.ack_tgl;
      next_l.cnt = sscol_pkg::BAUD_ZERO;
      next_l.state = sscol_pkg::ST_IDLE;
    end else if (finish) begin
      // Normal end of a sequence
      next_l.coll = 1'b0;
      next_l.ack_tgl = ~l.ack_tgl;
      next_l.state = sscol_pkg::ST_IDLE;
    end
  end

  // Link state register
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      l <= '{
        state: sscol_pkg::ST_IDLE,
        cnt: sscol_pkg::BAUD_ZERO,
        sda_oe: sscol_pkg::LINE_FREE,
        scl_oe: sscol_pkg::LINE_FREE,
        sda_out: sscol_pkg::DRIVE_LEVEL,
        scl_out: sscol_pkg::DRIVE_LEVEL,
        req_seen: sscol_pkg::TGL_INIT,
        ack_tgl: sscol_pkg::TGL_INIT,
        coll: 1'b0
      };
    end else begin
      l <= next_l;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // User status straight from system flops
  assign BUSY = s.busy;
  assign DONE = s.done;
  assign BUS_COLLISION_FLAG = s.coll_flag;

  // Open drain lines straight from link flops
  assign SDA_OUT = l.sda_out;
  assign SDA_OE = l.sda_oe;
  assign SCL_OUT = l.scl_out;
  assign SCL_OE = l.scl_oe;

endmodule

// ### sim/sscol_peer.sv
`timescale 1ns/1ps
module sscol_peer (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic rst,
  // Bench requests to pull a line low
  input wire logic hold_sda,
  input wire logic hold_scl,
  input wire logic [7:0] stretch,
  // Enables of the block
  input wire logic dut_sda_oe,
  input wire logic dut_scl_oe,
  // Wire levels
  output logic sda,
  output logic scl
);
  logic [7:0] stretch_cnt; // Cycles SCL is still held low
  logic scl_oe_q; // Previous enable of the block on SCL
  // Hold SCL low a while after the block frees it
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      stretch_cnt <= 8'h00;
      scl_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= dut_scl_oe;
      if (scl_oe_q && !dut_scl_oe) begin
        stretch_cnt <= stretch;
      end else if (stretch_cnt != 8'h00) begin
        stretch_cnt <= stretch_cnt - 8'h01;
      end
    end
  end
  // Pulled-up wires: low while any party pulls
  assign sda = !(dut_sda_oe || hold_sda);
  assign scl = !(dut_scl_oe || hold_scl || stretch_cnt != 8'h00 || (scl_oe_q && stretch != 8'h00));
endmodule

// ### sim/sscol_top_assertions.sv
`timescale 1ns/1ps
module sscol_top_assertions (
  // Clocks and reset
  input wire logic MCLK,
  input wire logic RST,
  input wire logic LINK_CLK,
  // User side
  input wire logic START_REQ,
  input wire logic STOP_REQ,
  input wire logic [sscol_pkg::BAUD_W-1:0] BAUD_RELOAD,
  input wire logic COLLISION_CLEAR,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic BUS_COLLISION_FLAG,
  // Bus enables
  input wire logic SDA_OE,
  input wire logic SCL_OE
);
  // ----------------------------------------
  // Helper: link edges since SDA was pulled
  // ----------------------------------------
  logic [8:0] hold_cnt; // Saturating count, all ones when unused
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      hold_cnt <= 9'h1ff;
    end else if ($rose(SDA_OE)) begin
      hold_cnt <= 9'h000;
    end else if (hold_cnt != 9'h1ff) begin
      hold_cnt <= hold_cnt + 9'h001;
    end
  end
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence s_sda_first; // Start: SDA pulled while SCL still free
    $rose(SDA_OE) && !SCL_OE;
  endsequence
  sequence s_scl_follows; // SCL stays free a while, then is pulled
    !SCL_OE[*3] ##[1:300] SCL_OE;
  endsequence
  a_done_ends_busy: assert property (@(posedge MCLK) disable iff (RST) DONE |-> !BUSY)
    else $error("busy still high with done");
  a_done_single: assert property (@(posedge MCLK) disable iff (RST) DONE |=> !DONE)
    else $error("done longer than one cycle");
  a_req_taken: assert property (@(posedge MCLK) disable iff (RST) (START_REQ || STOP_REQ) && !BUSY |=> BUSY)
    else $error("request not taken");
  a_flag_with_done: assert property (@(posedge MCLK) disable iff (RST) $rose(BUS_COLLISION_FLAG) |-> DONE)
    else $error("collision flag set without done");
  a_flag_sticky: assert property (@(posedge MCLK) disable iff (RST)
    BUS_COLLISION_FLAG && !COLLISION_CLEAR |=> BUS_COLLISION_FLAG)
    else $error("collision flag dropped by itself");
  a_lines_released: assert property (@(posedge MCLK) disable iff (RST)
    $rose(BUS_COLLISION_FLAG) |-> !SDA_OE && !SCL_OE)
    else $error("lines held after collision");
  a_done_lines_pair: assert property (@(posedge MCLK) disable iff (RST) DONE |-> SDA_OE == SCL_OE)
    else $error("lines in mixed state at done");
  a_scl_after_sda: assert property (@(posedge LINK_CLK) disable iff (RST) $rose(SCL_OE) |-> SDA_OE)
    else $error("scl pulled while sda free");
  a_sda_free_order: assert property (@(posedge LINK_CLK) disable iff (RST) $fell(SDA_OE) |-> !SCL_OE)
    else $error("sda freed before scl");
  a_start_hold: assert property (@(posedge LINK_CLK) disable iff (RST) s_sda_first |-> s_scl_follows)
    else $error("second start count wrong");
  a_hold_count: assert property (@(posedge LINK_CLK) disable iff (RST)
    $rose(SCL_OE) && !$rose(SDA_OE) |-> hold_cnt == {1'b0, BAUD_RELOAD})
    else $error("second start count length wrong");
endmodule

bind sscol_top sscol_top_assertions u_chk (.MCLK(MCLK), .RST(RST), .LINK_CLK(LINK_CLK), .START_REQ(START_REQ),
  .STOP_REQ(STOP_REQ), .BAUD_RELOAD(BAUD_RELOAD), .COLLISION_CLEAR(COLLISION_CLEAR), .BUSY(BUSY), .DONE(DONE),
  .BUS_COLLISION_FLAG(BUS_COLLISION_FLAG), .SDA_OE(SDA_OE), .SCL_OE(SCL_OE));

// ### sim/test_sscol_top.sv
`timescale 1ns/1ps
module test_sscol_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic MCLK = 1'b0, RST = 1'b1, LINK_CLK = 1'b0;
  logic START_REQ = 1'b0, STOP_REQ = 1'b0, COLLISION_CLEAR = 1'b0;
  logic [sscol_pkg::BAUD_W-1:0] BAUD_RELOAD = 8'h05;
  logic BUSY, DONE, BUS_COLLISION_FLAG, SDA_IN, SDA_OE, SCL_IN, SCL_OE;
  logic SDA_OUT, SCL_OUT; // Levels driven while an enable is high
  logic hold_sda = 1'b0, hold_scl = 1'b0; // Other party pulls
  logic [7:0] stretch = 8'h00; // Other party's SCL hold
  int n_mismatch = 0, checked = 0;
  always #25 MCLK = ~MCLK;
  // Link clock edges meet a system clock edge once every 400 ns
  always #80 LINK_CLK = ~LINK_CLK;
  sscol_top u_dut (.MCLK(MCLK), .RST(RST), .LINK_CLK(LINK_CLK), .START_REQ(START_REQ), .STOP_REQ(STOP_REQ),
    .BAUD_RELOAD(BAUD_RELOAD), .COLLISION_CLEAR(COLLISION_CLEAR), .BUSY(BUSY), .DONE(DONE),
    .BUS_COLLISION_FLAG(BUS_COLLISION_FLAG), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SCL_IN(SCL_IN),
    .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE));
  sscol_peer u_peer (.link_clk(LINK_CLK), .rst(RST), .hold_sda(hold_sda), .hold_scl(hold_scl),
    .stretch(stretch), .dut_sda_oe(SDA_OE), .dut_scl_oe(SCL_OE), .sda(SDA_IN), .scl(SCL_IN));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One command, then wait for done under a bound
  task automatic run(input logic stop, input sscol_pkg::baud_t reload);
    int n;
    n = 0;
    @(posedge MCLK);
    START_REQ <= !stop;
    STOP_REQ <= stop;
    BAUD_RELOAD <= reload;
    @(posedge MCLK);
    START_REQ <= 1'b0;
    STOP_REQ <= 1'b0;
    while (DONE !== 1'b1 && n < 20000) begin
      @(negedge MCLK);
      n++;
    end
    if (n == 20000) n_mismatch++;
  endtask
  // Outcome at the done cycle
  task automatic expect_end(input logic flag, input logic oe);
    check(BUS_COLLISION_FLAG, flag);
    check(SDA_OE, oe);
    check(SCL_OE, oe);
    check(BUSY, 1'b0);
    check(SDA_OUT, 1'b0);
    check(SCL_OUT, 1'b0);
  endtask
  task automatic clear_flag;
    @(posedge MCLK);
    COLLISION_CLEAR <= 1'b1;
    @(posedge MCLK);
    COLLISION_CLEAR <= 1'b0;
    @(negedge MCLK);
    check(BUS_COLLISION_FLAG, 1'b0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_start_stop_ok;
    fork
      run(1'b0, 8'h05);
      begin
        wait (SDA_OE === 1'b1);
        hold_scl <= 1'b1;
        repeat (3) @(posedge LINK_CLK);
        hold_scl <= 1'b0;
      end
    join
    expect_end(1'b0, 1'b1);
    stretch <= 8'h06;
    run(1'b1, 8'h05);
    expect_end(1'b0, 1'b0);
    stretch <= 8'h00;
    $display("test start_stop_ok done");
  endtask
  task automatic t_lines_low;
    for (int i = 0; i < 2; i++) begin
      hold_sda <= (i == 0);
      hold_scl <= (i == 1);
      repeat (5) @(posedge LINK_CLK);
      run(1'b0, 8'h05);
      expect_end(1'b1, 1'b0);
      hold_sda <= 1'b0;
      hold_scl <= 1'b0;
      clear_flag;
    end
    $display("test lines_low done");
  endtask
  task automatic t_scl_mid_start;
    fork
      run(1'b0, 8'h28);
      begin
        repeat (12) @(negedge LINK_CLK);
        check(SDA_OE, 1'b0);
        @(posedge MCLK);
        STOP_REQ <= 1'b1;
        hold_scl <= 1'b1;
        @(posedge MCLK);
        STOP_REQ <= 1'b0;
      end
    join
    expect_end(1'b1, 1'b0);
    hold_scl <= 1'b0;
    repeat (40) @(negedge MCLK);
    check(BUSY, 1'b0);
    clear_flag;
    $display("test scl_mid_start done");
  endtask
  task automatic t_early_sda_and_stop_sda;
    fork
      run(1'b0, 8'h28);
      begin
        repeat (12) @(posedge LINK_CLK);
        hold_sda <= 1'b1;
        repeat (8) @(negedge LINK_CLK);
        check(SDA_OE, 1'b1);
      end
    join
    expect_end(1'b0, 1'b1);
    run(1'b1, 8'h05);
    expect_end(1'b1, 1'b0);
    hold_sda <= 1'b0;
    clear_flag;
    $display("test early_sda_and_stop_sda done");
  endtask
  task automatic t_stop_scl;
    run(1'b0, 8'h05);
    expect_end(1'b0, 1'b1);
    fork
      run(1'b1, 8'h28);
      begin
        wait (SCL_OE === 1'b0);
        repeat (10) @(negedge LINK_CLK);
        check(SDA_OE, 1'b1);
        hold_scl <= 1'b1;
      end
    join
    expect_end(1'b1, 1'b0);
    hold_scl <= 1'b0;
    clear_flag;
    $display("test stop_scl done");
  endtask
  // ----------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge MCLK);
    RST <= 1'b0;
    repeat (4) @(posedge LINK_CLK);
    t_start_stop_ok;
    t_lines_low;
    t_scl_mid_start;
    t_early_sda_and_stop_sda;
    t_stop_scl;
    report_and_stop;
  end
  initial begin
    #2000000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
